// ==== ecl_pkg.sv ====
/*
  Constants, types and field helpers for the EEPROM configuration loader.
  Assumes a 40 MHz core clock and a two-wire serial EEPROM with pull-ups on both lines.
*/
// What this block does
// [RULE_01] Master mode runs only while the four-level enable strap sits at float.
// [RULE_02] EEPROM is addressed as A0 hex; bus clock stays at or below 400 kHz.
// [RULE_03] Own address byte comes from the four address straps; zero gives B0.
// [RULE_04] No EEPROM access starts until the load grant input is low.
// [RULE_05] First device has grant tied low; others take previous device's done.
// [RULE_06] Active-low load done asserts once the configuration has been loaded.
// [RULE_07] First three EEPROM bytes form a common header read before any image.
// [RULE_08] Header byte zero bit 7 enables CRC checking of the image.
// [RULE_09] With CRC disabled the CRC location must hold A5 hex.
// [RULE_10] Map flag takes start address from the map, else from own address.
// [RULE_11] Large-EEPROM flag selects two-byte word addressing.
// [RULE_12] Exactly 37 configuration bytes are fetched per device.
// [RULE_13] Path selects and input mode come only from straps, never from the image.
// [RULE_14] Image byte 3 holds per-channel power-down bits, default all powered.
// [RULE_15] Image byte 4 bit 3 overrides the low-power strap; other bits reserved.
// [RULE_16] Image byte 6: rx-detect override, mode override, 3-bit delay default 7.
// [RULE_17] Image byte 8 is the channel 0 boost code, default 2F hex.
// [RULE_18] Channel 1 swing and de-emphasis sit in bits 6..1 of image byte 13.
// [RULE_19] A load-complete status bit sets after the EEPROM read finishes.
// [RULE_20] Sixteen address bytes from B0 upward in steps of two.
// [RULE_21] Bytes are read in ascending order and stored before done asserts.
// [RULE_22] Done stays asserted until reset; both bus lines released at the end.
package ecl_pkg;
  // Timing: quarter-bit count rounds up so the bus never exceeds its rate
  localparam int CLK_PERIOD_NS = 25;
  localparam int I2C_BIT_NS    = 2500;
  localparam int QTR_CYCLES    = (I2C_BIT_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);

  // Bus addresses and strap codes
  localparam logic [7:0] EEPROM_DEV_WR  = 8'hA0;
  localparam logic [7:0] EEPROM_DEV_RD  = 8'hA1;
  localparam logic [7:0] OWN_ADDR_BASE  = 8'hB0;
  localparam logic [1:0] STRAP_FLOAT    = 2'h2;
  localparam logic [7:0] SYNC_RST       = 8'h81;

  // Image layout
  localparam int         HDR_LEN     = 3;
  localparam int         IMG_LEN     = 37;
  localparam int         MAP_BASE    = 3;
  localparam int         HDR_CRC_BIT = 7;
  localparam int         HDR_MAP_BIT = 6;
  localparam int         HDR_BIG_BIT = 5;
  localparam logic [7:0] CRC_FIXED   = 8'hA5;
  localparam logic [7:0] CRC_POLY    = 8'h07;
  localparam int BYTE_PWDN  = 3;
  localparam int BYTE_LOPWR = 4;
  localparam int LOPWR_BIT  = 3;
  localparam int BYTE_MISC  = 6;
  localparam int RXDET_BIT  = 6;
  localparam int MODE_BIT   = 5;
  localparam int BYTE_EQ0   = 8;
  localparam int BYTE_DRV1  = 13;

  typedef logic [7:0] ecl_img_t [IMG_LEN];

  // Image defaults, EEPROM addresses 3 upward
  localparam ecl_img_t IMG_DEFAULTS = '{
    8'h00, 8'h00, 8'h04, 8'h07, 8'h00, 8'h2F, 8'hAD, 8'h40, 8'h02, 8'hFA,
    8'hD4, 8'h00, 8'h2F, 8'hAD, 8'h40, 8'h02, 8'hFA, 8'hD4, 8'h01, 8'h80,
    8'h5F, 8'h5A, 8'h80, 8'h05, 8'hF5, 8'hA8, 8'h00, 8'h5F, 8'h5A, 8'h80,
    8'h05, 8'hF5, 8'hA8, 8'h00, 8'h00, 8'h54, 8'h54};

  typedef struct packed {
    logic [7:0] pwdn;
    logic       lopwr;
    logic       rxdet;
    logic       mode;
    logic [2:0] rxdly;
    logic [7:0] eq0;
    logic [2:0] swing;
    logic [2:0] deemph;
  } ecl_out_t;

  typedef enum logic [4:0] {ST_IDLE = 5'b00001, ST_START = 5'b00010, ST_BIT = 5'b00100,
                            ST_STOP = 5'b01000, ST_DONE = 5'b10000} ecl_state_t;
  typedef enum logic [3:0] {PH_DEVW = 4'b0001, PH_AHI = 4'b0010, PH_ALO = 4'b0100,
                            PH_DEVR = 4'b1000} ecl_addr_ph_t;
  typedef enum logic [2:0] {JOB_HDR = 3'b001, JOB_MAP = 3'b010, JOB_IMG = 3'b100} ecl_job_t;

  // Extract the applied settings from an image
  function automatic ecl_out_t ecl_fields(input ecl_img_t m);
    ecl_out_t o;
    o.pwdn   = m[BYTE_PWDN - HDR_LEN];
    o.lopwr  = m[BYTE_LOPWR - HDR_LEN][LOPWR_BIT];
    o.rxdet  = m[BYTE_MISC - HDR_LEN][RXDET_BIT];
    o.mode   = m[BYTE_MISC - HDR_LEN][MODE_BIT];
    o.rxdly  = m[BYTE_MISC - HDR_LEN][2:0];
    o.eq0    = m[BYTE_EQ0 - HDR_LEN];
    o.swing  = m[BYTE_DRV1 - HDR_LEN][6:4];
    o.deemph = m[BYTE_DRV1 - HDR_LEN][3:1];
    return o;
  endfunction

  // CRC-8 over one byte, MSB first
  function automatic logic [7:0] ecl_crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ((r << 1) ^ CRC_POLY) : (r << 1);
    end
    return r;
  endfunction
endpackage

// ==== ecl_fifo_if.sv ====
/*
  Byte stream carrier between the loader's bus engine and its image buffer.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface ecl_fifo_if #(parameter int W = 8);
  logic         push_valid;
  logic         push_ready;
  logic [W-1:0] push_data;
  logic         pop_valid;
  logic         pop_ready;
  logic [W-1:0] pop_data;
  modport fifo (input push_valid, push_data, pop_ready, output push_ready, pop_valid, pop_data);
  modport user (output push_valid, push_data, pop_ready, input push_ready, pop_valid, pop_data);
endinterface

// ==== ecl_sync.sv ====
/*
  Two-flop synchroniser for pins entering the core clock domain.
  Assumes inputs are static levels or slow compared with the clock.
*/
`timescale 1ns/1ps
module ecl_sync #(
  parameter int           W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         clk_i,
  input  wire logic         reset_n_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta;

  // First stage feeds only the second
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      meta <= RST;
      q_o  <= RST;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end
endmodule

// ==== ecl_fifo.sv ====
/*
  Synchronous FIFO with valid/ready on both sides.
  Assumes DEPTH is a power of two of at least two.
*/
`timescale 1ns/1ps
module ecl_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 8
) (
  input  wire logic clk_i,
  input  wire logic reset_n_i,
  ecl_fifo_if.fifo  fp
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("ecl_fifo: DEPTH must be a power of two, at least 2");
  end

  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wptr, next_wptr, rptr, next_rptr;
  logic         do_push, do_pop;

  // Full and empty from the wrap bit
  always_comb begin
    fp.push_ready = (wptr[AW] == rptr[AW]) || (wptr[AW-1:0] != rptr[AW-1:0]);
    fp.pop_valid  = (wptr != rptr);
    fp.pop_data   = mem[rptr[AW-1:0]];
    do_push       = fp.push_valid && fp.push_ready;
    do_pop        = fp.pop_valid && fp.pop_ready;
    next_wptr     = do_push ? wptr + 1'b1 : wptr;
    next_rptr     = do_pop ? rptr + 1'b1 : rptr;
  end

  // Pointers and storage
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wptr <= '0;
      rptr <= '0;
    end else begin
      wptr <= next_wptr;
      rptr <= next_rptr;
    end
  end

  always_ff @(posedge clk_i) begin
    if (do_push) begin
      mem[wptr[AW-1:0]] <= fp.push_data;
    end
  end
endmodule

// ==== ecl_loader.sv ====
/*
  Power-up configuration loader: two-wire bus master that reads a header and a
  37-byte image from a serial EEPROM and applies it to the redriver settings.
  Assumes external pull-ups on both bus lines and a daisy-chained grant input.
*/
`timescale 1ns/1ps
module ecl_loader #(
  parameter int QTR = ecl_pkg::QTR_CYCLES
) (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  // Straps and chain
  input  wire logic [1:0] serial_if_enable_strap_i,
  input  wire logic [3:0] addr_strap_i,
  input  wire logic       load_grant_n_i,
  output logic            load_done_n_o,
  // Two-wire bus, open drain
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_o,
  output logic            scl_o,
  output logic            scl_oe_o,
  // Write-back control and status
  input  wire logic       cfg_write_hold_i,
  output logic            load_complete_o,
  output logic            load_error_o,
  output logic [7:0]      dev_addr_o,
  // Applied settings
  output logic [7:0]      chan_powerdown_bits_o,
  output logic            low_power_override_o,
  output logic            rx_detect_override_o,
  output logic            mode_override_o,
  output logic [2:0]      rx_delay_sel_o,
  output logic [7:0]      eq_boost_code_o,
  output logic [2:0]      swing_code_o,
  output logic [2:0]      deemph_code_o
);
  import ecl_pkg::*;

  localparam int DW = $clog2(QTR + 1);

  if (QTR < 1) begin : g_bad_qtr
    $error("ecl_loader: QTR must be at least one cycle");
  end

  logic         grant_n_s, sda_s;
  logic [1:0]   ens_s;
  logic [3:0]   ad_s;
  ecl_fifo_if #(.W(8)) f ();

  // Pins enter through two flops
  ecl_sync #(.W(8), .RST(SYNC_RST)) u_sync (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .d_i       ({load_grant_n_i, serial_if_enable_strap_i, addr_strap_i, sda_i}),
    .q_o       ({grant_n_s, ens_s, ad_s, sda_s})
  );

  // Image buffer between bus engine and write-back
  ecl_fifo #(.W(8), .DEPTH(8)) u_fifo (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .fp        (f.fifo)
  );

  ecl_state_t   state, next_state;
  ecl_addr_ph_t aph, next_aph;
  ecl_job_t     job, next_job;
  logic         rx, next_rx;
  logic [1:0]   q, next_q;
  logic [3:0]   bitn, next_bitn;
  logic [8:0]   shreg, next_shreg;
  logic [15:0]  rd_addr, next_rd_addr;
  logic [5:0]   cnt, next_cnt, job_len;
  logic [2:0]   flags, next_flags;
  logic [7:0]   crc, next_crc;
  logic         err, next_err;
  logic         sda_rel, next_sda_rel, scl_rel, next_scl_rel;
  logic [DW-1:0] div_cnt, next_div_cnt;
  logic         qtick, running, last, stall, byte_end;
  logic [7:0]   rx_byte;
  logic [15:0]  calc_start;

  // Own address and default start address
  always_comb begin
    dev_addr_o = OWN_ADDR_BASE + {3'h0, ad_s, 1'b0}; // [RULE_03] [RULE_20]
    calc_start = 16'(HDR_LEN) + 16'(ad_s) * 16'(IMG_LEN);
  end

  // Quarter-bit divider, runs only during a transfer
  always_comb begin
    running      = (state == ST_START) || (state == ST_BIT) || (state == ST_STOP);
    qtick        = running && (div_cnt == DW'(QTR - 1)); // [RULE_02]
    next_div_cnt = (!running || qtick) ? '0 : div_cnt + 1'b1;
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= next_div_cnt;
    end
  end

  // Byte counts per job and end-of-byte decode
  always_comb begin
    case (job)
      JOB_HDR: job_len = 6'(HDR_LEN); // [RULE_07]
      JOB_MAP: job_len = 6'h01;
      default: job_len = 6'(IMG_LEN + 1); // [RULE_12]
    endcase
    last     = (cnt == job_len - 6'h01);
    rx_byte  = shreg[7:0];
    byte_end = (state == ST_BIT) && (q == 2'h3) && (bitn == 4'h8);
    stall    = byte_end && rx && (job == JOB_IMG) && (cnt < 6'(IMG_LEN)) && !f.push_ready;
    f.push_valid = qtick && byte_end && rx && (job == JOB_IMG) && (cnt < 6'(IMG_LEN));
    f.push_data  = rx_byte;
  end

  // Bus sequencer: header, optional map, image, each a random read
  always_comb begin
    next_state   = state;
    next_aph     = aph;
    next_job     = job;
    next_rx      = rx;
    next_q       = q;
    next_bitn    = bitn;
    next_shreg   = shreg;
    next_rd_addr = rd_addr;
    next_cnt     = cnt;
    next_flags   = flags;
    next_crc     = crc;
    next_err     = err;
    case (state)
      ST_IDLE: begin
        if (ens_s == STRAP_FLOAT && !grant_n_s) begin // [RULE_01] [RULE_04]
          next_state   = ST_START;
          next_job     = JOB_HDR;
          next_aph     = PH_DEVW;
          next_rx      = 1'b0;
          next_rd_addr = '0;
          next_q       = '0;
        end
      end
      ST_START: begin
        if (qtick) begin
          next_q = q + 2'h1;
          if (q == 2'h3) begin
            next_state = ST_BIT;
            next_bitn  = '0;
            next_shreg = {(aph == PH_DEVR) ? EEPROM_DEV_RD : EEPROM_DEV_WR, 1'b1}; // [RULE_02]
          end
        end
      end
      ST_BIT: begin
        if (qtick && !stall) begin
          next_q = q + 2'h1;
          if (q == 2'h3) begin
            next_shreg = {shreg[7:0], sda_s};
            next_bitn  = bitn + 4'h1;
            if (bitn == 4'h8) begin
              next_bitn = '0;
              if (!rx && sda_s) begin
                next_err   = 1'b1;
                next_state = ST_STOP;
              end else if (!rx) begin
                case (aph)
                  PH_DEVW: begin
                    next_aph   = flags[0] ? PH_AHI : PH_ALO; // [RULE_11]
                    next_shreg = {flags[0] ? rd_addr[15:8] : rd_addr[7:0], 1'b1};
                  end
                  PH_AHI: begin
                    next_aph   = PH_ALO;
                    next_shreg = {rd_addr[7:0], 1'b1};
                  end
                  PH_ALO: begin
                    next_aph   = PH_DEVR;
                    next_state = ST_START;
                  end
                  default: begin
                    next_rx  = 1'b1;
                    next_cnt = '0;
                  end
                endcase
              end else begin
                next_cnt = cnt + 6'h01; // [RULE_21]
                if (last) begin
                  next_state = ST_STOP;
                end
                case (job)
                  JOB_HDR: begin
                    if (cnt == 6'h00) begin // [RULE_07] [RULE_08] [RULE_10]
                      next_flags = {rx_byte[HDR_CRC_BIT], rx_byte[HDR_MAP_BIT],
                                    rx_byte[HDR_BIG_BIT]};
                    end
                  end
                  JOB_MAP: next_rd_addr = {8'h00, rx_byte}; // [RULE_10]
                  default: begin
                    if (cnt < 6'(IMG_LEN)) begin
                      next_crc = ecl_crc8(crc, rx_byte); // [RULE_08]
                    end else if (rx_byte != (flags[2] ? crc : CRC_FIXED)) begin // [RULE_09]
                      next_err = 1'b1;
                    end
                  end
                endcase
              end
            end
          end
        end
      end
      ST_STOP: begin
        if (qtick) begin
          next_q = q + 2'h1;
          if (q == 2'h3) begin
            if (err || job == JOB_IMG) begin
              next_state = ST_DONE;
            end else begin
              next_state = ST_START;
              next_aph   = PH_DEVW;
              next_rx    = 1'b0;
              next_cnt   = '0;
              next_crc   = '0;
              if (job == JOB_HDR) begin // [RULE_10]
                next_rd_addr = flags[1] ? 16'(MAP_BASE) + 16'(ad_s) : calc_start;
                next_job     = flags[1] ? JOB_MAP : JOB_IMG;
              end else begin
                next_job = JOB_IMG;
              end
            end
          end
        end
      end
      ST_DONE: next_state = ST_DONE;
      default: next_state = ST_IDLE;
    endcase
    // Line levels for the quarter being entered
    case (next_state)
      ST_START: begin
        next_scl_rel = (next_q == 2'h1) || (next_q == 2'h2);
        next_sda_rel = (next_q < 2'h2);
      end
      ST_STOP: begin
        next_scl_rel = (next_q != 2'h0);
        next_sda_rel = (next_q >= 2'h2);
      end
      ST_BIT: begin
        next_scl_rel = (next_q >= 2'h2);
        next_sda_rel = !next_rx ? next_shreg[8] : ((next_bitn == 4'h8) ? last : 1'b1);
      end
      default: begin
        next_scl_rel = 1'b1; // [RULE_22]
        next_sda_rel = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state   <= ST_IDLE;
      aph     <= PH_DEVW;
      job     <= JOB_HDR;
      rx      <= 1'b0;
      q       <= '0;
      bitn    <= '0;
      shreg   <= '1;
      rd_addr <= '0;
      cnt     <= '0;
      flags   <= '0;
      crc     <= '0;
      err     <= 1'b0;
      sda_rel <= 1'b1;
      scl_rel <= 1'b1;
    end else begin
      state   <= next_state;
      aph     <= next_aph;
      job     <= next_job;
      rx      <= next_rx;
      q       <= next_q;
      bitn    <= next_bitn;
      shreg   <= next_shreg;
      rd_addr <= next_rd_addr;
      cnt     <= next_cnt;
      flags   <= next_flags;
      crc     <= next_crc;
      err     <= next_err;
      sda_rel <= next_sda_rel;
      scl_rel <= next_scl_rel;
    end
  end

  // Open-drain drive: enable pulls the line low
  assign sda_o    = 1'b0;
  assign scl_o    = 1'b0;
  assign sda_oe_o = !sda_rel;
  assign scl_oe_o = !scl_rel;

  ecl_img_t  cfg, next_cfg;
  logic [5:0] wr_idx, next_wr_idx;
  logic      done, next_done, fin;
  ecl_out_t  outs, next_outs;

  // Write-back of image bytes in ascending order, then apply and finish
  always_comb begin
    f.pop_ready = !cfg_write_hold_i && !done;
    next_cfg    = cfg;
    next_wr_idx = wr_idx;
    if (f.pop_valid && f.pop_ready) begin
      next_cfg[wr_idx] = f.pop_data; // [RULE_21]
      next_wr_idx      = wr_idx + 6'h01;
    end
    fin       = (state == ST_DONE) && !f.pop_valid && (err || wr_idx == 6'(IMG_LEN));
    next_done = done || fin; // [RULE_06] [RULE_22]
    next_outs = outs;
    if (fin && !done && !err) begin
      next_outs = ecl_fields(cfg); // [RULE_13] [RULE_14] [RULE_15] [RULE_16] [RULE_17] [RULE_18]
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cfg    <= IMG_DEFAULTS;
      wr_idx <= '0;
      done   <= 1'b0;
      outs   <= ecl_fields(IMG_DEFAULTS);
    end else begin
      cfg    <= next_cfg;
      wr_idx <= next_wr_idx;
      done   <= next_done;
      outs   <= next_outs;
    end
  end

  // Status and applied settings
  assign load_done_n_o         = !done; // [RULE_06] [RULE_05]
  assign load_complete_o       = done; // [RULE_19]
  assign load_error_o          = done && err;
  assign chan_powerdown_bits_o = outs.pwdn;
  assign low_power_override_o  = outs.lopwr;
  assign rx_detect_override_o  = outs.rxdet;
  assign mode_override_o       = outs.mode;
  assign rx_delay_sel_o        = outs.rxdly;
  assign eq_boost_code_o       = outs.eq0;
  assign swing_code_o          = outs.swing;
  assign deemph_code_o         = outs.deemph;
endmodule

// ==== ecl_eeprom_model.sv ====
/*
  Behavioural two-wire serial EEPROM that answers at device address A0.
  Assumes pull-ups on both lines; pull_o high means the model pulls SDA low.
*/
`timescale 1ns/1ps
module ecl_eeprom_model (
  // Bus lines as seen on the board
  input  wire logic scl_i,
  input  wire logic sda_i,
  // Scenario control and data line pull
  input  wire logic mute_i,
  output logic      pull_o
);
  logic [7:0]  mem [512];
  logic [7:0]  sh;
  logic [15:0] ptr;
  logic        act = 0;
  logic        rd = 0;
  int          bc;
  int          nb;
  // Erased contents and a released line
  initial begin
    foreach (mem[i]) mem[i] = 8'hFF;
    pull_o = 0;
  end
  // Start restarts the byte count
  always @(negedge sda_i) if (scl_i === 1'b1) begin
    act = 1;
    bc = -1;
    nb = -1;
  end
  // Stop ends all activity
  always @(posedge sda_i) if (scl_i === 1'b1) begin
    act = 0;
    pull_o = 0;
  end
  // Sample on the rising clock; a NACK from the master ends a read
  always @(posedge scl_i) if (act) begin
    if (bc < 8) sh = {sh[6:0], sda_i};
    else if (rd && nb > 0 && sda_i) act = 0;
  end
  // Drive on the falling clock: ACK after each address or written byte, read data MSB first
  always @(negedge scl_i) if (act) begin
    bc = (bc == 8) ? 0 : bc + 1;
    if (bc == 0) nb = nb + 1;
    if (bc == 8) begin
      pull_o = (nb == 0) ? (sh[7:1] == 7'h50 && !mute_i) : !rd;
      if (nb == 0) rd = sh[0];
      if (nb == 0 && !rd) ptr = 16'h0;
      else if (nb > 0) ptr = rd ? ptr + 16'h1 : {ptr[7:0], sh};
    end else pull_o = rd && nb > 0 && !mem[ptr[8:0]][7 - bc];
  end
endmodule

// ==== ecl_loader_assertions.sv ====
/*
  Concurrent checks on the loader's top-level ports.
  Assumes it is bound to ecl_loader and gets its quarter-bit parameter.
*/
`timescale 1ns/1ps
module ecl_loader_assertions #(
  parameter int QTR = 2
) (
  // Clock and reset
  input wire logic       clk_i,
  input wire logic       reset_n_i,
  // Straps and chain
  input wire logic [1:0] serial_if_enable_strap_i,
  input wire logic [3:0] addr_strap_i,
  input wire logic       load_grant_n_i,
  input wire logic       load_done_n_o,
  // Bus enables and status
  input wire logic       sda_oe_o,
  input wire logic       scl_oe_o,
  input wire logic       load_complete_o,
  input wire logic [7:0] dev_addr_o
);
  import ecl_pkg::*;
  int unsigned hi_cnt;
  int unsigned next_hi_cnt;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // Cycles the clock line has spent released
  always_comb next_hi_cnt = scl_oe_o ? 0 : hi_cnt + 1;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) hi_cnt <= 0;
    else hi_cnt <= next_hi_cnt;
  end
  // Start and stop shapes on the two lines
  sequence s_start;
    $rose(sda_oe_o) && !scl_oe_o;
  endsequence
  sequence s_stop;
    $fell(sda_oe_o) && !scl_oe_o;
  endsequence
  a_done_sticky: assert property (!load_done_n_o |=> !load_done_n_o)
    else $error("load done released");
  a_done_status: assert property (load_done_n_o == !load_complete_o)
    else $error("done and complete disagree");
  a_grant_gate: assert property (load_grant_n_i [*3] |-> !scl_oe_o && !sda_oe_o)
    else $error("bus used without grant");
  a_strap_gate: assert property ((serial_if_enable_strap_i != STRAP_FLOAT) [*3] |-> !scl_oe_o)
    else $error("bus used with strap off float");
  a_own_addr: assert property ($stable(addr_strap_i) [*4] |->
    dev_addr_o == OWN_ADDR_BASE + {3'h0, addr_strap_i, 1'h0})
    else $error("own address wrong");
  a_scl_high_time: assert property ($rose(scl_oe_o) |-> hi_cnt >= 2 * QTR)
    else $error("clock high too short");
  a_start_shape: assert property (s_start |-> ##QTR scl_oe_o)
    else $error("start not followed by clock low");
  a_stop_release: assert property (s_stop |=> !scl_oe_o && !sda_oe_o)
    else $error("lines not released after stop");
endmodule

// ==== ecl_loader_tb.sv ====
/*
  Self-checking bench for the EEPROM configuration loader.
  Assumes the EEPROM model and the checker are compiled before this file.
*/
`timescale 1ns/1ps
module ecl_loader_tb;
  import ecl_pkg::*;
  localparam logic [27:0] DEF = {8'h00, 3'h0, 3'h7, 8'h2F, 6'h2A};
  logic       clk_i = 0;
  logic       reset_n_i = 0;
  logic       load_grant_n_i = 1;
  logic       cfg_write_hold_i = 0;
  logic [1:0] serial_if_enable_strap_i = STRAP_FLOAT;
  logic [3:0] addr_strap_i = 4'h0;
  logic       mute = 0;
  logic       pull;
  logic       sda_o, scl_o, load_done_n_o, sda_oe_o, scl_oe_o, load_complete_o, load_error_o;
  logic       low_power_override_o, rx_detect_override_o, mode_override_o;
  logic [7:0] dev_addr_o, chan_powerdown_bits_o, eq_boost_code_o;
  logic [2:0] rx_delay_sel_o, swing_code_o, deemph_code_o;
  int         n_errors = 0;
  int         checks_done = 0;
  wire        sda = !(sda_oe_o || pull);
  wire        scl = !scl_oe_o;
  // Slave view of SDA lags SCL, as its internal data hold time does
  wire #5     sda_m = sda;
  wire [27:0] sets = {chan_powerdown_bits_o, low_power_override_o, rx_detect_override_o,
    mode_override_o, rx_delay_sel_o, eq_boost_code_o, swing_code_o, deemph_code_o};
  // 40 MHz clock
  always #12.5 clk_i = !clk_i;
  ecl_loader #(.QTR(2)) DUT (
    .clk_i, .reset_n_i, .serial_if_enable_strap_i, .addr_strap_i, .load_grant_n_i,
    .load_done_n_o, .sda_i(sda), .sda_o, .sda_oe_o, .scl_o, .scl_oe_o,
    .cfg_write_hold_i, .load_complete_o, .load_error_o, .dev_addr_o,
    .chan_powerdown_bits_o, .low_power_override_o, .rx_detect_override_o,
    .mode_override_o, .rx_delay_sel_o, .eq_boost_code_o, .swing_code_o, .deemph_code_o
  );
  ecl_eeprom_model EE (.scl_i(scl), .sda_i(sda_m), .mute_i(mute), .pull_o(pull));
  // Compare one result and count it
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  // Print counts and the verdict, then stop
  task automatic test_done;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Settings expected from image bytes 3, 4, 6, 8 and 13 at start b
  function automatic logic [27:0] fld(input int b);
    return {EE.mem[b], EE.mem[b+1][3], EE.mem[b+3][6:5], EE.mem[b+3][2:0], EE.mem[b+5],
      EE.mem[b+10][6:1]};
  endfunction
  // CRC-8, polynomial 07, bit-serial over the 37 image bytes
  function automatic logic [7:0] crc(input int b);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < IMG_LEN * 8; i++)
      c = {c[6:0], 1'h0} ^ ((c[7] ^ EE.mem[b + i / 8][7 - i % 8]) ? 8'h07 : 8'h00);
    return c;
  endfunction
  // Header, image and check byte into the EEPROM model
  task automatic put(input logic [7:0] hdr, input int b, input logic [7:0] sd, input logic en);
    EE.mem[0] = hdr;
    for (int k = 0; k < IMG_LEN; k++) EE.mem[b + k] = sd + 8'(k * 29);
    EE.mem[b + IMG_LEN] = en ? crc(b) : 8'hA5;
  endtask
  // Reset with grant off, then one load, optionally stalled at write-back
  task automatic run(input int id, input logic [3:0] st, input int hold, input logic err,
                     input logic [27:0] exp);
    int n;
    @(posedge clk_i);
    reset_n_i <= 0;
    load_grant_n_i <= 1;
    addr_strap_i <= st;
    repeat (3) @(posedge clk_i);
    reset_n_i <= 1;
    repeat (40) @(posedge clk_i);
    #1 chk(sets, DEF);
    chk({scl_o, sda_o, scl_oe_o, sda_oe_o, load_done_n_o}, 5'h01);
    @(posedge clk_i);
    load_grant_n_i <= 0;
    cfg_write_hold_i <= hold > 0;
    repeat (hold) @(posedge clk_i);
    #1 chk(load_done_n_o, 1'h1);
    @(posedge clk_i);
    cfg_write_hold_i <= 0;
    for (n = 0; n < 12000 && load_done_n_o !== 1'h0; n++) @(posedge clk_i);
    repeat (5) @(posedge clk_i);
    #1 chk({load_done_n_o, load_complete_o, load_error_o, scl_oe_o, sda_oe_o},
           {2'h1, err, 2'h0});
    chk(sets, exp);
    $display("test %0d done", id);
  endtask
  // Main sequence
  initial begin
    #1;  // Let the model erase its memory first
    EE.mem[4] = 8'hA0;
    put(8'h40, 8'hA0, 8'h3C, 0);
    run(1, 4'h1, 0, 0, fld(8'hA0));
    put(8'hA0, 3 + 7 * IMG_LEN, 8'hC7, 1);
    run(2, 4'h7, 3000, 0, fld(3 + 7 * IMG_LEN));
    put(8'h00, 3 + 2 * IMG_LEN, 8'h5E, 0);
    EE.mem[3 + 3 * IMG_LEN] = 8'h5A;
    run(3, 4'h2, 0, 1, DEF);
    mute = 1;
    run(4, 4'h0, 0, 1, DEF);
    mute = 0;
    @(posedge clk_i);
    reset_n_i <= 0;
    serial_if_enable_strap_i <= 2'h0;
    repeat (3) @(posedge clk_i);
    reset_n_i <= 1;
    for (int i = 0; i < 16; i++) begin
      @(posedge clk_i);
      addr_strap_i <= i[3:0];
      repeat (4) @(posedge clk_i);
      #1 chk(dev_addr_o, 8'hB0 + 8'(2 * i));
    end
    for (int j = 1; j < 4; j++) begin
      @(posedge clk_i);
      serial_if_enable_strap_i <= (j == 2) ? 2'h0 : j[1:0];
      repeat (500) @(posedge clk_i);
      #1 chk({scl_oe_o, load_done_n_o}, 2'h1);
    end
    $display("test 5 done");
    test_done;
  end
  // Watchdog well beyond the expected run length
  initial begin
    #(25 * 90000);
    n_errors++;
    test_done;
  end
endmodule
bind ecl_loader ecl_loader_assertions #(.QTR(QTR)) CHK (
  .clk_i, .reset_n_i, .serial_if_enable_strap_i, .addr_strap_i, .load_grant_n_i,
  .load_done_n_o, .sda_oe_o, .scl_oe_o, .load_complete_o, .dev_addr_o
);
